// File: hdl/srs_pkg.sv
// Shared constants for the sweep and RAM segment control link
package srs_pkg;
  // Register addresses carried in the instruction byte
  localparam logic [4:0] A_CTRL1 = 5'h00;
  localparam logic [4:0] A_CTRL2 = 5'h01;
  localparam logic [4:0] A_FTW = 5'h04;
  localparam logic [4:0] A_POW = 5'h05;
  localparam logic [4:0] A_UPPER = 5'h06;
  localparam logic [4:0] A_SEG0 = 5'h07;
  localparam logic [4:0] A_SEG1 = 5'h08;
  localparam logic [4:0] A_SEG2 = 5'h09;
  localparam logic [4:0] A_SEG3 = 5'h0A;
  localparam logic [3:0] SEG_BASE = A_SEG0[3:0];
  localparam int NREG = 11;
  localparam int INSTR_WR_BIT = 7;
  // Control word fields
  localparam int C1_SWEEP = 21;
  localparam int C1_PH_AUTOCLR = 13;
  localparam int C1_NO_DWELL = 2;
  localparam int C2_MULT_MSB = 7;
  localparam int C2_MULT_LSB = 3;
  localparam int C2_VCO_HIGH = 2;
  // Sweep word: rate in the top byte, delta below
  localparam int SW_RATE_MSB = 39;
  localparam int SW_RATE_LSB = 32;
  // Segment word fields
  localparam int SG_DWELL_MSB = 39;
  localparam int SG_DWELL_LSB = 24;
  localparam int SG_MODE_MSB = 7;
  localparam int SG_MODE_LSB = 5;
  localparam int SG_NO_DWELL = 4;
  // RAM modes
  localparam logic [2:0] RM_DIRECT = 3'h0;
  localparam logic [2:0] RM_RECIRC = 3'h4;
  localparam logic [2:0] RM_MAX = 3'h4;
  // Timing
  localparam int SYNC_DIV = 4;
  localparam int HALF_DIV = 2;
  localparam logic [39:0] WORD_RST = 40'h00_0000_0000;
  // Host register byte offsets
  localparam logic [4:0] H_DATA_LO = 5'h00;
  localparam logic [4:0] H_DATA_HI = 5'h04;
  localparam logic [4:0] H_CMD = 5'h08;
  localparam logic [4:0] H_STATUS = 5'h0C;
  localparam logic [4:0] H_PROFILE = 5'h10;
  localparam int H_CMD_UPD = 8;
  localparam int H_CMD_UPD_ONLY = 9;

  typedef enum logic [1:0] {HS_IDLE, HS_SHIFT, HS_UPD} srs_hstate_e;

  // Bytes per register, zero when unmapped
  function automatic logic [2:0] reg_bytes(input logic [4:0] a);
    case (a)
      A_CTRL1, A_FTW, A_UPPER: reg_bytes = 3'h4;
      A_CTRL2: reg_bytes = 3'h3;
      A_POW: reg_bytes = 3'h2;
      A_SEG0, A_SEG1, A_SEG2, A_SEG3: reg_bytes = 3'h5;
      default: reg_bytes = 3'h0;
    endcase
  endfunction : reg_bytes

  function automatic logic [39:0] reg_mask(input logic [2:0] n);
    reg_mask = ~(40'hFF_FFFF_FFFF << {n, 3'b000});
  endfunction : reg_mask
endpackage : srs_pkg

// File: hdl/srs_if.sv
// Serial programming link between host and device
`timescale 1ns/10ps
`default_nettype none
interface srs_if;
  logic sclk;
  logic cs_n;
  logic sdata;
  logic io_update;
  logic [1:0] profile;
  modport dev (
    input sclk,
    input cs_n,
    input sdata,
    input io_update,
    input profile
  );
  modport host (
    output sclk,
    output cs_n,
    output sdata,
    output io_update,
    output profile
  );
endinterface : srs_if
`default_nettype wire

// File: hdl/srs_tick.sv
// Divider giving a one-cycle enable every N clocks
`timescale 1ns/10ps
`default_nettype none
module srs_tick #(
  parameter int N = 4
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  output logic tick
);
  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } srs_tick_s;

  srs_tick_s st;
  srs_tick_s next_st;

  always_comb
  begin
    next_st = st;
    next_st.tick = (st.cnt == 8'(N - 1));
    next_st.cnt = next_st.tick ? 8'h00 : st.cnt + 8'h01;
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      st <= '0;
    else
      st <= next_st;
  end

  assign tick = st.tick;
endmodule : srs_tick
`default_nettype wire

// File: hdl/srs_dev.sv
// Device end: serial register bank, sweep and RAM segment control
`timescale 1ns/10ps
`default_nettype none
module srs_dev (
  input wire logic clk_sys,
  input wire logic sys_rst,
  srs_if.dev link,
  output logic [31:0] tune_word,
  output logic [15:0] phase_offset,
  output logic phase_clear,
  output logic [9:0] ram_addr,
  output logic ram_active,
  output logic [4:0] clk_mult,
  output logic vco_high,
  output logic sweep_done
);
  typedef struct packed {
    logic sclk_q;
    logic upd_q;
    logic [1:0] prof_q;
    logic [5:0] bits;
    logic [4:0] addr;
    logic wr;
    logic [39:0] sh;
    logic [srs_pkg::NREG-1:0][39:0] bufr;
    logic [srs_pkg::NREG-1:0][39:0] wrk;
    logic [31:0] acc;
    logic [7:0] rtimer;
    logic done;
    logic [9:0] raddr;
    logic [15:0] dwell;
    logic ractive;
    logic pclr;
  } srs_dev_s;

  srs_dev_s st;
  srs_dev_s next_st;
  logic tick;
  logic upd_rise;
  logic prof_chg;
  logic rise;
  logic sweep;
  logic [2:0] nbytes;
  logic [31:0] primary_tuning_word;
  logic [31:0] upper;
  logic [31:0] delta;
  logic [7:0] rate;
  logic [32:0] up_sum;
  logic [32:0] dn_sum;
  logic [39:0] seg;
  logic [9:0] s_start;
  logic [9:0] s_end;
  logic [2:0] s_mode;

  // ----------------------------------------------------------------
  // Sync clock enable
  // ----------------------------------------------------------------
  // quarter-rate enable
  srs_tick #(
    .N(srs_pkg::SYNC_DIV)
  ) u_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .tick(tick)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    upd_rise = link.io_update & ~st.upd_q;
    prof_chg = (link.profile != st.prof_q);
    nbytes = srs_pkg::reg_bytes(st.addr);
    next_st.sclk_q = link.sclk;
    next_st.upd_q = link.io_update;
    next_st.prof_q = link.profile;
    if (link.cs_n)
      next_st.bits = 6'h00;
    else if (link.sclk && !st.sclk_q)
    begin
      next_st.sh = {st.sh[38:0], link.sdata};
      if (st.bits != 6'h3F)
        next_st.bits = st.bits + 6'h01;
      if (st.bits == 6'h07)
      begin
        next_st.addr = next_st.sh[4:0];
        next_st.wr = ~next_st.sh[srs_pkg::INSTR_WR_BIT];
      end
      // data waits in the shadow buffer
      else if (st.wr && nbytes != 3'h0 && st.bits == {nbytes, 3'b111})
        next_st.bufr[st.addr[3:0]] = next_st.sh &
          srs_pkg::reg_mask(nbytes);
    end
    if (upd_rise)
      next_st.wrk = next_st.bufr;

    sweep = next_st.wrk[srs_pkg::A_CTRL1][srs_pkg::C1_SWEEP];
    rise = link.profile[0];
    primary_tuning_word = next_st.wrk[srs_pkg::A_FTW][31:0];
    upper = next_st.wrk[srs_pkg::A_UPPER][31:0];
    delta = rise ? next_st.wrk[srs_pkg::A_SEG1][31:0] :
      next_st.wrk[srs_pkg::A_SEG0][31:0];
    rate = rise ?
      next_st.wrk[srs_pkg::A_SEG1][srs_pkg::SW_RATE_MSB:srs_pkg::SW_RATE_LSB] :
      next_st.wrk[srs_pkg::A_SEG0][srs_pkg::SW_RATE_MSB:srs_pkg::SW_RATE_LSB];
    up_sum = {1'b0, st.acc} + {1'b0, delta};
    dn_sum = {1'b0, st.acc} - {1'b0, delta};
    seg = next_st.wrk[srs_pkg::SEG_BASE + {2'b00, link.profile}];
    s_start = {seg[3:0], seg[15:10]};
    s_end = {seg[9:8], seg[23:16]};
    s_mode = seg[srs_pkg::SG_MODE_MSB:srs_pkg::SG_MODE_LSB];

    // ----------------------------------------------------------------
    // Sweep and RAM sequencing
    // ----------------------------------------------------------------
    if (upd_rise || prof_chg)
    begin
      next_st.done = 1'b0;
      next_st.rtimer = rate;
      if (upd_rise)
        next_st.acc = primary_tuning_word;
      next_st.raddr = s_start;
      next_st.dwell = seg[srs_pkg::SG_DWELL_MSB:srs_pkg::SG_DWELL_LSB];
      next_st.ractive = 1'b1;
    end
    else if (tick && sweep && !st.done)
    begin
      // hold each value for rate ticks
      if (st.rtimer > 8'h01)
        next_st.rtimer = st.rtimer - 8'h01;
      else
      begin
        next_st.rtimer = rate;
        if (rise && up_sum >= {1'b0, upper})
        begin
          next_st.acc = upper;
          next_st.done = 1'b1;
        end
        else if (rise)
          next_st.acc = up_sum[31:0];
        else if (dn_sum[32] || dn_sum[31:0] <= primary_tuning_word)
        begin
          next_st.acc = primary_tuning_word;
          next_st.done = 1'b1;
        end
        else
          next_st.acc = dn_sum[31:0];
      end
    end
    else if (tick && !sweep && st.ractive)
    begin
      if (s_mode == srs_pkg::RM_DIRECT || s_mode > srs_pkg::RM_MAX)
        next_st.ractive = 1'b0;
      else if (st.dwell > 16'h0001)
        next_st.dwell = st.dwell - 16'h0001;
      else
      begin
        next_st.dwell = seg[srs_pkg::SG_DWELL_MSB:srs_pkg::SG_DWELL_LSB];
        if (st.raddr != s_end)
          next_st.raddr = st.raddr + 10'h001;
        else if (s_mode == srs_pkg::RM_RECIRC)
          next_st.raddr = s_start;
        else
        begin
          next_st.ractive = 1'b0;
          if (seg[srs_pkg::SG_NO_DWELL])
            next_st.raddr = s_start;
        end
      end
    end
    if (!sweep)
      next_st.acc = primary_tuning_word;
    next_st.pclr =
      (upd_rise && next_st.wrk[srs_pkg::A_CTRL1][srs_pkg::C1_PH_AUTOCLR]) ||
      (next_st.done && sweep &&
       next_st.wrk[srs_pkg::A_CTRL1][srs_pkg::C1_NO_DWELL]);
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      st <= '0;
    else
      st <= next_st;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign tune_word = st.acc;
  assign phase_offset = st.wrk[srs_pkg::A_POW][15:0];
  assign phase_clear = st.pclr;
  assign ram_addr = st.raddr;
  assign ram_active = st.ractive;
  assign clk_mult =
    st.wrk[srs_pkg::A_CTRL2][srs_pkg::C2_MULT_MSB:srs_pkg::C2_MULT_LSB];
  assign vco_high = st.wrk[srs_pkg::A_CTRL2][srs_pkg::C2_VCO_HIGH];
  assign sweep_done = st.done;
endmodule : srs_dev
`default_nettype wire

// File: hdl/srs_host.sv
// Host end: Avalon-MM command registers driving the serial link
`timescale 1ns/10ps
`default_nettype none
module srs_host (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  srs_if.host link
);
  typedef struct packed {
    logic wreq;
    logic [31:0] rdata;
    logic [31:0] dlo;
    logic [7:0] dhi;
    logic [9:0] cmd;
    logic refused;
    logic [1:0] profile;
    logic sweep_en;
    srs_pkg::srs_hstate_e state;
    logic do_upd;
    logic [47:0] frame;
    logic [5:0] left;
    logic sclk;
    logic cs_n;
    logic sdata;
    logic upd;
  } srs_host_s;

  srs_host_s st;
  srs_host_s next_st;
  logic half;
  logic req;
  logic blocked;
  logic [4:0] a;
  logic [2:0] nb;
  logic bad_seg;
  logic [39:0] data;

  srs_tick #(
    .N(srs_pkg::HALF_DIV)
  ) u_half (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .tick(half)
  );

  always_comb
  begin
    next_st = st;
    next_st.upd = 1'b0;
    req = avs_read | avs_write;
    blocked = avs_write && avs_address == srs_pkg::H_CMD &&
      st.state != srs_pkg::HS_IDLE;
    a = avs_writedata[4:0];
    nb = srs_pkg::reg_bytes(a);
    data = {st.dhi, st.dlo};
    bad_seg = !st.sweep_en && a >= srs_pkg::A_SEG0 && a <= srs_pkg::A_SEG3 &&
      (data[39:24] == 16'h0000 || data[7:5] > srs_pkg::RM_MAX);

    // ----------------------------------------------------------------
    // Register slave
    // ----------------------------------------------------------------
    if (!st.wreq)
    begin
      next_st.wreq = 1'b1;
      if (avs_write)
        case (avs_address)
          srs_pkg::H_DATA_LO: next_st.dlo = avs_writedata;
          srs_pkg::H_DATA_HI: next_st.dhi = avs_writedata[7:0];
          srs_pkg::H_PROFILE: next_st.profile = avs_writedata[1:0];
          srs_pkg::H_CMD:
          begin
            next_st.cmd = avs_writedata[9:0];
            next_st.do_upd = avs_writedata[srs_pkg::H_CMD_UPD];
            next_st.refused = 1'b0;
            if (avs_writedata[srs_pkg::H_CMD_UPD_ONLY])
              next_st.state = srs_pkg::HS_UPD;
            else if (nb == 3'h0 || bad_seg)
              next_st.refused = 1'b1;
            else
            begin
              next_st.frame = {3'b000, a, data << {3'h5 - nb, 3'b000}};
              next_st.left = {nb, 3'b000} + 6'h08;
              next_st.state = srs_pkg::HS_SHIFT;
              next_st.cs_n = 1'b0;
              next_st.sdata = 1'b0;
              if (a == srs_pkg::A_CTRL1)
                next_st.sweep_en = st.dlo[srs_pkg::C1_SWEEP];
            end
          end
          default: ;
        endcase
    end
    else if (req && !blocked)
    begin
      next_st.wreq = 1'b0;
      case (avs_address)
        srs_pkg::H_DATA_LO: next_st.rdata = st.dlo;
        srs_pkg::H_DATA_HI: next_st.rdata = {24'h00_0000, st.dhi};
        srs_pkg::H_CMD: next_st.rdata = {22'h00_0000, st.cmd};
        srs_pkg::H_STATUS: next_st.rdata = {30'h0000_0000, st.refused,
          st.state != srs_pkg::HS_IDLE};
        srs_pkg::H_PROFILE: next_st.rdata = {30'h0000_0000, st.profile};
        default: next_st.rdata = 32'h0000_0000;
      endcase
    end

    // ----------------------------------------------------------------
    // Serial sequencer
    // ----------------------------------------------------------------
    unique case (st.state)
      srs_pkg::HS_IDLE: ;
      srs_pkg::HS_SHIFT:
        if (half && !st.sclk)
          next_st.sclk = 1'b1;
        else if (half)
        begin
          next_st.sclk = 1'b0;
          next_st.left = st.left - 6'h01;
          next_st.frame = {st.frame[46:0], 1'b0};
          next_st.sdata = st.frame[46];
          if (st.left == 6'h01)
          begin
            next_st.cs_n = 1'b1;
            next_st.sdata = 1'b0;
            next_st.state = st.do_upd ? srs_pkg::HS_UPD : srs_pkg::HS_IDLE;
          end
        end
        else if (!st.sclk)
          next_st.sdata = st.frame[47];
      srs_pkg::HS_UPD:
      begin
        next_st.upd = 1'b1;
        next_st.state = srs_pkg::HS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st <= '0;
      st.wreq <= 1'b1;
      st.cs_n <= 1'b1;
    end
    else
      st <= next_st;
  end

  assign avs_readdata = st.rdata;
  assign avs_waitrequest = st.wreq;
  assign link.sclk = st.sclk;
  assign link.cs_n = st.cs_n;
  assign link.sdata = st.sdata;
  assign link.io_update = st.upd;
  assign link.profile = st.profile;
endmodule : srs_host
`default_nettype wire

// File: tb/srs_assertions.sv
// Assertions on the serial link between host and device
`timescale 1ns/10ps
`default_nettype none
module srs_assertions (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdata,
  input wire logic io_update,
  input wire logic [1:0] profile
);
  // ----------------------------------------
  // Frame bit counter and instruction byte
  // ----------------------------------------
  logic [7:0] nbits;
  logic [7:0] instr;
  logic sclk_q;
  logic rise;
  assign rise = sclk && !sclk_q;
  // Frame length in bits for an instruction
  function automatic logic [7:0] flen(input logic [7:0] i);
    case (i[4:0])
      5'h00, 5'h04, 5'h06: flen = 8'h28;
      5'h01: flen = 8'h20;
      5'h05: flen = 8'h18;
      default: flen = 8'h30;
    endcase
  endfunction : flen
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      nbits <= 8'h00;
      instr <= 8'h00;
      sclk_q <= 1'b0;
    end
    else
    begin
      sclk_q <= sclk;
      if (cs_n)
        nbits <= 8'h00;
      else if (rise)
        nbits <= nbits + 8'h01;
      if (!cs_n && rise && nbits < 8'h08)
        instr <= {instr[6:0], sdata};
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  // ----------------------------------------
  // Link properties
  // ----------------------------------------
  sclk_idle_a: assert property (cs_n |-> !sclk)
    else $error("sclk high outside a frame");
  sclk_high_a: assert property ($rose(sclk) |=> sclk ##1 !sclk)
    else $error("sclk high phase not two cycles");
  sclk_low_a: assert property ($fell(sclk) |=> !sclk)
    else $error("sclk low phase too short");
  data_hold_a: assert property (sclk && $past(sclk)
    |-> $stable(sdata))
    else $error("sdata moved while sclk high");
  first_bit_a: assert property (rise && nbits == 8'h00 |-> !sdata)
    else $error("instruction is not a write");
  frame_len_a: assert property ($rose(cs_n)
    |-> nbits == flen(instr))
    else $error("frame length does not match register");
  upd_pulse_a: assert property (io_update |=> !io_update)
    else $error("update pulse longer than one cycle");
  upd_idle_a: assert property (io_update |-> cs_n && !sclk)
    else $error("update inside a frame");
endmodule : srs_assertions
`default_nettype wire

// File: tb/tb_top.sv
// Bench joining host and device ends over the serial link
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [31:0] tune_word;
  logic [15:0] phase_offset;
  logic phase_clear;
  logic [9:0] ram_addr;
  logic ram_active;
  logic [4:0] clk_mult;
  logic vco_high;
  logic sweep_done;
  logic [7:0] pc_count = 8'h00;
  logic [7:0] pc_mark;
  logic [31:0] rd;
  int fail_count = 0;
  int checks = 0;
  srs_if link ();
  srs_host i_srs_host (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .link(link));
  srs_dev i_srs_dev (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(link),
    .tune_word(tune_word), .phase_offset(phase_offset),
    .phase_clear(phase_clear), .ram_addr(ram_addr), .ram_active(ram_active),
    .clk_mult(clk_mult), .vco_high(vco_high), .sweep_done(sweep_done));
  srs_assertions i_srs_assertions (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .sclk(link.sclk), .cs_n(link.cs_n), .sdata(link.sdata),
    .io_update(link.io_update), .profile(link.profile));
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
    if (phase_clear === 1'b1)
      pc_count <= pc_count + 8'h01;
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  task automatic av(input logic wr, input logic [4:0] a,
    input logic [31:0] d);
    int n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0 && n < 5000)
    begin
      n++;
      @(posedge clk_sys);
    end
    if (n >= 5000)
      fail_count++;
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : av
  // Frame a register then wait until the sequencer is idle
  task automatic send(input logic [4:0] a, input logic [39:0] w,
    input logic [1:0] upd);
    int n = 0;
    av(1'b1, srs_pkg::H_DATA_LO, w[31:0]);
    av(1'b1, srs_pkg::H_DATA_HI, {24'h00_0000, w[39:32]});
    av(1'b1, srs_pkg::H_CMD, {22'h00_0000, upd, 3'h0, a});
    rd = 32'h0000_0001;
    while (rd[0] !== 1'b0 && n < 500)
    begin
      av(1'b0, srs_pkg::H_STATUS, 32'h0000_0000);
      n++;
    end
    if (n >= 500)
      fail_count++;
    repeat (4) @(posedge clk_sys);
  endtask : send
  task automatic refuse(input logic [4:0] a, input logic [39:0] w);
    send(a, w, 2'b01);
    chk(rd[1:0], 2'b10);
  endtask : refuse
  task automatic prof(input logic [1:0] p, input int wait_n);
    av(1'b1, srs_pkg::H_PROFILE, {30'h0000_0000, p});
    repeat (wait_n) @(posedge clk_sys);
  endtask : prof
  function automatic logic [39:0] seg(input logic [15:0] dw,
    input logic [9:0] s, input logic [9:0] e, input logic [2:0] m,
    input logic nd);
    seg = {dw, e[7:0], s[5:0], e[9:8], m, nd, s[9:6]};
  endfunction : seg
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    repeat (30000) @(posedge clk_sys);
    fail_count++;
    give_verdict();
  end
  initial
  begin
    repeat (20) @(posedge clk_sys);
    chk({link.cs_n, link.sclk, link.io_update, avs_waitrequest},
      4'h9);
    chk(tune_word, 32'h0000_0000);
    chk({phase_offset, ram_addr, ram_active, clk_mult, vco_high, sweep_done,
      phase_clear}, 40'h00_0000_0000);
    sys_rst <= 1'b0;
    av(1'b1, srs_pkg::H_DATA_LO, 32'h1234_5678);
    av(1'b0, srs_pkg::H_DATA_LO, 32'h0000_0000);
    chk(rd, 32'h1234_5678);
    av(1'b0, 5'h14, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    $display("test host_regs finished");
    send(srs_pkg::A_CTRL2, 40'h00_0000_00A4, 2'b00);
    chk(clk_mult, 5'h00);
    send(srs_pkg::A_CTRL2, 40'h00_0000_00A4, 2'b10);
    chk({clk_mult, vco_high}, 6'h29);
    send(srs_pkg::A_CTRL1, 40'h00_0000_2000, 2'b01);
    send(srs_pkg::A_FTW, 40'h00_4E14_7AE1, 2'b01);
    pc_mark = pc_count;
    send(srs_pkg::A_POW, 40'h00_0000_0800, 2'b01);
    chk(tune_word, 32'h4E14_7AE1);
    chk({pc_count - pc_mark, phase_offset}, 24'h01_0800);
    $display("test commit finished");
    refuse(5'h02, 40'h00_0000_0000);
    refuse(srs_pkg::A_SEG0,
      seg(16'h0000, 10'h001, 10'h002, 3'h1, 1'b0));
    refuse(srs_pkg::A_SEG1,
      seg(16'h0001, 10'h001, 10'h002, 3'h5, 1'b0));
    $display("test refusal finished");
    for (int m = 0; m < 5; m++)
    begin
      send(srs_pkg::A_SEG0, seg(16'h0010, 10'h2C5, 10'h2C8, 3'(m), 1'b0),
        2'b01);
      chk(ram_addr, 10'h2C5);
      repeat (300) @(posedge clk_sys);
      if (m == 4)
        chk(ram_active, 1'b1);
      else
        chk(ram_addr, (m == 0) ? 10'h2C5 : 10'h2C8);
    end
    send(srs_pkg::A_SEG0, seg(16'h0010, 10'h2C5, 10'h2C8, 3'h1, 1'b1), 2'b01);
    // Dwell of 16 sync ticks is 64 clocks per address
    repeat (50) @(posedge clk_sys);
    chk(ram_addr, 10'h2C5);
    repeat (10) @(posedge clk_sys);
    chk(ram_addr, 10'h2C6);
    repeat (240) @(posedge clk_sys);
    chk(ram_addr, 10'h2C5);
    send(srs_pkg::A_SEG2, seg(16'h0010, 10'h011, 10'h013, 3'h1, 1'b0), 2'b01);
    prof(2'h2, 300);
    chk(ram_addr, 10'h013);
    $display("test ram_segments finished");
    prof(2'h0, 1);
    send(srs_pkg::A_CTRL1, 40'h00_0020_0004, 2'b00);
    send(srs_pkg::A_FTW, 40'h00_1000_0000, 2'b00);
    send(srs_pkg::A_UPPER, 40'h00_1000_0100, 2'b00);
    send(srs_pkg::A_SEG1, 40'h20_0000_0060, 2'b00);
    send(srs_pkg::A_SEG0, 40'h01_0000_0030, 2'b01);
    chk(tune_word, 32'h1000_0000);
    chk({sweep_done, phase_clear}, 2'b11);
    prof(2'h1, 60);
    chk(tune_word, 32'h1000_0000);
    chk({sweep_done, phase_clear}, 2'b00);
    repeat (600) @(posedge clk_sys);
    chk(tune_word, 32'h1000_0100);
    chk(sweep_done, 1'b1);
    prof(2'h0, 100);
    chk(tune_word, 32'h1000_0000);
    chk(phase_clear, 1'b1);
    $display("test sweep finished");
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
